// ===== hdl/fpes_pkg.sv
// Constants, types and states for the flash program/erase sequencer.
// Assumes one 40 MHz clock shared by the core bus and the sequencer.
// Contract
// - Erased bytes read FFh; programming only clears bits; erase is per sector or whole.
// - Program running: polling flag is inverse of data bit 7, then true.
// - Error flag set on program timeout or an attempt to turn zero into one.
// - Erase running: polling flag zero, error means timeout, readable across the sector.
// - Toggle flag changes on every status read while busy, then stops.
// - Two unlock cycles then 20h enter bypass mode, which persists.
// - In bypass a program is A0h then address and data, repeatable.
// - In bypass only bypass program and bypass exit are accepted.
// - Bypass exit is 90h then 00h, any address, back to read mode.
// - Bulk erase takes six writes; a wrong byte aborts; busy refuses all.
// - Bulk erase programs all bytes to zero before erasing to ones.
// - Bulk erase error flag set when erase pass limit is used up.
// - Sector erase after six writes; more sector codes restart a 100us window.
// - Erase window flag zero while window counts, one once erase runs.
// - Inside the window any command but suspend or resume aborts to read.
// - Running sector erase accepts only reset and suspend.
// - Suspend B0h with a sector select, only during erase; ends the window.
// - After suspend toggle stops within 0.1 to 15us; then read mode.
// - Suspended: erasing sector invalid, others valid; only resume and reset.
// - Resume 30h with a sector select continues the suspended erase.
// - Unlock cycles are AAh at 555h then 55h at AAAh.
// - Reset command aborts sector erase within 25us; ignored in program or bulk.
package fpes_pkg;
  // ==========================================================================
  // Geometry
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 8;
  localparam int PRI_SECT    = 8;
  localparam int SEC_SECT    = 4;
  localparam int NUM_SECT    = PRI_SECT + SEC_SECT;
  localparam int SECT_W      = 4;
  localparam int OFS_W       = 4;
  localparam int IDX_W       = SECT_W + OFS_W;
  localparam int ARRAY_BYTES = NUM_SECT * (2 ** OFS_W);
  localparam int CMD_ADDR_W  = 12;
  localparam int CNT_W       = 12;
  localparam int PASS_W      = 3;

  // ==========================================================================
  // Command bytes and unlock addresses
  localparam logic [7:0] CMD_UNLOCK1   = 8'h_AA;
  localparam logic [7:0] CMD_UNLOCK2   = 8'h_55;
  localparam logic [7:0] CMD_BYPASS    = 8'h_20;
  localparam logic [7:0] CMD_PROGRAM   = 8'h_A0;
  localparam logic [7:0] CMD_BYP_EXIT1 = 8'h_90;
  localparam logic [7:0] CMD_BYP_EXIT2 = 8'h_00;
  localparam logic [7:0] CMD_ERASE_SET = 8'h_80;
  localparam logic [7:0] CMD_BULK      = 8'h_10;
  localparam logic [7:0] CMD_SECTOR    = 8'h_30;
  localparam logic [7:0] CMD_SUSPEND   = 8'h_B0;
  localparam logic [7:0] CMD_RESUME    = 8'h_30;
  localparam logic [7:0] CMD_RESET     = 8'h_F0;
  localparam logic [CMD_ADDR_W-1:0] UNLOCK_ADDR1 = 12'h_555;
  localparam logic [CMD_ADDR_W-1:0] UNLOCK_ADDR2 = 12'h_AAA;

  // ==========================================================================
  // Data values and status byte layout
  localparam logic [7:0] ERASED_BYTE  = 8'h_FF;
  localparam logic [7:0] ZERO_BYTE    = 8'h_00;
  localparam logic [7:0] INVALID_BYTE = 8'h_00;
  localparam int POLL_BIT = 7;
  localparam int TOG_BIT  = 6;
  localparam int ERR_BIT  = 5;
  localparam int WIN_BIT  = 3;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS    = 25;
  localparam int WINDOW_NS        = 100000;
  localparam int WINDOW_CYCLES    = WINDOW_NS / CLK_PERIOD_NS;
  localparam int SUSP_MIN_NS      = 100;
  localparam int SUSP_MAX_NS      = 15000;
  localparam int SUSP_CYCLES      = (SUSP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUSP_MAX_CYCLES  = SUSP_MAX_NS / CLK_PERIOD_NS;
  localparam int PROG_WR_CYCLES   = 8;
  localparam int PROG_TMO_CYCLES  = 64;
  localparam int ERASE_PASS_LIMIT = 4;

  // ==========================================================================
  // Types
  typedef enum logic [4:0] {
    ST_READ, ST_UNLK1, ST_UNLK2, ST_PROG_ADDR, ST_PROG_BUSY, ST_PROG_ERR,
    ST_ERS3, ST_ERS4, ST_ERS5, ST_BULK_BUSY, ST_BULK_ERR, ST_WINDOW,
    ST_SE_BUSY, ST_SUSPENDING, ST_SUSPENDED, ST_BYP, ST_BYP_PROG, ST_BYP_EXIT
  } fpes_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } fpes_bus_req_t;
endpackage

// ===== hdl/fpes_sequencer.sv
// Flash program/erase sequencer: command decode, embedded algorithms, status.
// Assumes the core bus and sector selects come from logic on core_clk.
`timescale 1ns/1ps
module fpes_sequencer import fpes_pkg::*; (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                srst,
  // Core bus
  input  wire fpes_bus_req_t       bus_req,
  output logic [DATA_W-1:0]        rdata,
  // Sector selects from address decode
  input  wire logic [PRI_SECT-1:0] primary_sector_selects,
  input  wire logic [SEC_SECT-1:0] secondary_sector_selects,
  // Status pin, high when ready
  output logic                     ready_busy_pin
);
  // ==========================================================================
  // Declarations
  fpes_state_t            state_reg, state_next;
  logic [DATA_W-1:0]      mem [0:ARRAY_BYTES-1];
  logic [CNT_W-1:0]       cnt_reg;
  logic [IDX_W-1:0]       walk_reg;
  logic [IDX_W-1:0]       prog_idx_reg;
  logic [DATA_W-1:0]      prog_data_reg;
  logic                   byp_reg;
  logic [NUM_SECT-1:0]    ers_mask_reg;
  logic [NUM_SECT-1:0]    invalid_reg;
  logic [1:0]             bulk_phase_reg;
  logic [PASS_W-1:0]      pass_reg;
  logic                   vfail_reg;
  logic                   err_reg;
  logic                   tog_reg;
  logic [DATA_W-1:0]      rdata_reg;
  logic                   ready_reg;
  logic [NUM_SECT-1:0]    sel;
  logic                   any_sel;
  logic [SECT_W-1:0]      sect;
  logic [IDX_W-1:0]       idx;
  logic                   wr, rd;
  logic [7:0]             wd;
  logic                   at1, at2;
  logic                   mem_we;
  logic [IDX_W-1:0]       mem_wa;
  logic [DATA_W-1:0]      mem_wd;
  logic                   walk_last;
  logic                   prog_done, prog_tmo;
  logic                   bulk_end, bulk_fail;
  logic                   status_rd;
  logic [DATA_W-1:0]      status_byte;

  // ==========================================================================
  // Bus decode; secondary selects take priority over primary ones
  assign sel     = {secondary_sector_selects, primary_sector_selects};
  assign any_sel = |sel;
  assign wr      = bus_req.wr;
  assign rd      = bus_req.rd;
  assign wd      = bus_req.wdata;
  assign at1     = bus_req.addr[CMD_ADDR_W-1:0] == UNLOCK_ADDR1;
  assign at2     = bus_req.addr[CMD_ADDR_W-1:0] == UNLOCK_ADDR2;
  assign idx     = {sect, bus_req.addr[OFS_W-1:0]};

  // Sector number from the one-hot selects
  always_comb begin
    sect = '0;
    for (int i = 0; i < NUM_SECT; i++) begin
      if (sel[i]) begin
        sect = SECT_W'(i);
      end
    end
  end

  assign walk_last = walk_reg == IDX_W'(ARRAY_BYTES - 1);
  // Verify after the write slot; a byte that still differs cannot ever match
  assign prog_done = cnt_reg > CNT_W'(PROG_WR_CYCLES)
                     && mem[prog_idx_reg] == prog_data_reg;
  assign prog_tmo  = cnt_reg == CNT_W'(PROG_TMO_CYCLES);
  assign bulk_end  = bulk_phase_reg == 2'd2 && walk_last;
  assign bulk_fail = vfail_reg || mem[walk_reg] != ERASED_BYTE;

  // ==========================================================================
  // Command sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_READ: begin
        if (wr && wd == CMD_UNLOCK1 && at1) begin
          state_next = ST_UNLK1;
        end
      end
      ST_UNLK1: begin
        if (wr) begin
          state_next = (wd == CMD_UNLOCK2 && at2) ? ST_UNLK2 : ST_READ;
        end
      end
      ST_UNLK2: begin
        if (wr) begin
          if (wd == CMD_PROGRAM) begin
            state_next = ST_PROG_ADDR;
          end else if (wd == CMD_BYPASS) begin
            state_next = ST_BYP;
          end else if (wd == CMD_ERASE_SET) begin
            state_next = ST_ERS3;
          end else begin
            state_next = ST_READ;
          end
        end
      end
      ST_PROG_ADDR, ST_BYP_PROG: begin
        if (wr) begin
          state_next = any_sel ? ST_PROG_BUSY : ST_READ;
        end
      end
      ST_PROG_BUSY: begin
        // Commands are refused while the byte is being written
        if (prog_done) begin
          state_next = byp_reg ? ST_BYP : ST_READ;
        end else if (prog_tmo) begin
          state_next = ST_PROG_ERR;
        end
      end
      ST_PROG_ERR, ST_BULK_ERR: begin
        if (wr && wd == CMD_RESET) begin
          state_next = ST_READ;
        end
      end
      ST_ERS3: begin
        if (wr) begin
          state_next = (wd == CMD_UNLOCK1 && at1) ? ST_ERS4 : ST_READ;
        end
      end
      ST_ERS4: begin
        if (wr) begin
          state_next = (wd == CMD_UNLOCK2 && at2) ? ST_ERS5 : ST_READ;
        end
      end
      ST_ERS5: begin
        if (wr) begin
          if (wd == CMD_BULK && at1) begin
            state_next = ST_BULK_BUSY;
          end else if (wd == CMD_SECTOR && any_sel) begin
            state_next = ST_WINDOW;
          end else begin
            state_next = ST_READ;
          end
        end
      end
      ST_BULK_BUSY: begin
        if (bulk_end) begin
          if (!bulk_fail) begin
            state_next = ST_READ;
          end else if (pass_reg == PASS_W'(ERASE_PASS_LIMIT - 1)) begin
            state_next = ST_BULK_ERR;
          end
        end
      end
      ST_WINDOW: begin
        if (wr && wd == CMD_SUSPEND && any_sel) begin
          state_next = ST_SUSPENDING;
        end else if (wr && !(wd == CMD_SECTOR && any_sel)) begin
          state_next = ST_READ;
        end else if (!wr && cnt_reg == CNT_W'(WINDOW_CYCLES - 1)) begin
          state_next = ST_SE_BUSY;
        end
      end
      ST_SE_BUSY: begin
        if (wr && wd == CMD_SUSPEND && any_sel) begin
          state_next = ST_SUSPENDING;
        end else if (wr && wd == CMD_RESET) begin
          state_next = ST_READ;
        end else if (walk_last) begin
          state_next = ST_READ;
        end
      end
      ST_SUSPENDING: begin
        if (cnt_reg == CNT_W'(SUSP_CYCLES - 1)) begin
          state_next = ST_SUSPENDED;
        end
      end
      ST_SUSPENDED: begin
        if (wr && wd == CMD_RESUME && any_sel) begin
          state_next = ST_SE_BUSY;
        end else if (wr && wd == CMD_RESET) begin
          state_next = ST_READ;
        end
      end
      ST_BYP: begin
        // Anything but the two bypass commands is dropped
        if (wr && wd == CMD_PROGRAM) begin
          state_next = ST_BYP_PROG;
        end else if (wr && wd == CMD_BYP_EXIT1) begin
          state_next = ST_BYP_EXIT;
        end
      end
      ST_BYP_EXIT: begin
        if (wr) begin
          state_next = (wd == CMD_BYP_EXIT2) ? ST_READ : ST_BYP;
        end
      end
    endcase
  end

  // State register; chip reset returns to read mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= ST_READ;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Shared cycle counter: window, program timer and suspend latency
  always_ff @(posedge core_clk) begin
    if (srst || state_next != state_reg) begin
      cnt_reg <= '0;
    end else if (state_reg == ST_WINDOW && wr) begin
      cnt_reg <= '0;
    end else if (cnt_reg != '1) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Program target and bypass return flag
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prog_idx_reg  <= '0;
      prog_data_reg <= ERASED_BYTE;
      byp_reg       <= 1'b0;
    end else begin
      if ((state_reg == ST_PROG_ADDR || state_reg == ST_BYP_PROG) && wr) begin
        prog_idx_reg  <= idx;
        prog_data_reg <= wd;
        byp_reg       <= state_reg == ST_BYP_PROG;
      end
    end
  end

  // Sectors chosen for erase, and sectors left invalid by an abort
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ers_mask_reg <= '0;
      invalid_reg  <= '0;
    end else begin
      if (state_reg == ST_ERS5) begin
        ers_mask_reg <= sel;
      end else if (state_reg == ST_WINDOW && wr && wd == CMD_SECTOR) begin
        ers_mask_reg <= ers_mask_reg | sel;
      end
      if ((state_reg == ST_SE_BUSY || state_reg == ST_SUSPENDED)
          && state_next == ST_READ && wr) begin
        invalid_reg <= invalid_reg | ers_mask_reg;
      end else if (state_reg == ST_SE_BUSY && walk_last) begin
        invalid_reg <= invalid_reg & ~ers_mask_reg;
      end
    end
  end

  // ==========================================================================
  // Erase walker: one byte per cycle, held still while suspended
  always_ff @(posedge core_clk) begin
    if (srst) begin
      walk_reg       <= '0;
      bulk_phase_reg <= 2'd0;
      pass_reg       <= '0;
      vfail_reg      <= 1'b0;
    end else if (state_reg == ST_BULK_BUSY) begin
      walk_reg <= walk_last ? '0 : walk_reg + 1'b1;
      if (bulk_phase_reg == 2'd2) begin
        vfail_reg <= walk_last ? 1'b0 : bulk_fail;
      end
      if (walk_last) begin
        bulk_phase_reg <= (bulk_phase_reg == 2'd2) ? 2'd1 : bulk_phase_reg + 2'd1;
        if (bulk_end) begin
          pass_reg <= pass_reg + 1'b1;
        end
      end
    end else if (state_reg == ST_SE_BUSY) begin
      walk_reg <= walk_last ? '0 : walk_reg + 1'b1;
    end else if (state_reg != ST_SUSPENDING && state_reg != ST_SUSPENDED) begin
      walk_reg       <= '0;
      bulk_phase_reg <= 2'd0;
      pass_reg       <= '0;
      vfail_reg      <= 1'b0;
    end
  end

  // ==========================================================================
  // Array write port; programming can only clear bits
  always_comb begin
    mem_we = 1'b0;
    mem_wa = walk_reg;
    mem_wd = ERASED_BYTE;
    if (state_reg == ST_PROG_BUSY && cnt_reg == CNT_W'(PROG_WR_CYCLES)) begin
      mem_we = 1'b1;
      mem_wa = prog_idx_reg;
      mem_wd = mem[prog_idx_reg] & prog_data_reg;
    end else if (state_reg == ST_BULK_BUSY && bulk_phase_reg != 2'd2) begin
      mem_we = 1'b1;
      mem_wd = (bulk_phase_reg == 2'd0) ? ZERO_BYTE : ERASED_BYTE;
    end else if (state_reg == ST_SE_BUSY) begin
      mem_we = ers_mask_reg[walk_reg[IDX_W-1:OFS_W]];
    end
  end

  // Storage has no reset; contents survive a chip reset
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // ==========================================================================
  // Status flags
  always_ff @(posedge core_clk) begin
    if (srst) begin
      err_reg <= 1'b0;
    end else if (state_next == ST_PROG_ERR || state_next == ST_BULK_ERR) begin
      err_reg <= 1'b1;
    end else if (state_next == ST_READ) begin
      err_reg <= 1'b0;
    end
  end

  // Which reads return status instead of array data
  always_comb begin
    status_rd = 1'b0;
    unique case (state_reg)
      ST_PROG_BUSY, ST_PROG_ERR:
        status_rd = any_sel && idx == prog_idx_reg;
      ST_BULK_BUSY, ST_BULK_ERR:
        status_rd = any_sel;
      ST_WINDOW, ST_SE_BUSY, ST_SUSPENDING:
        status_rd = |(sel & ers_mask_reg);
      default:
        status_rd = 1'b0;
    endcase
  end

  // Status byte; unflagged bits read as zero
  always_comb begin
    status_byte           = '0;
    status_byte[POLL_BIT] = (state_reg == ST_PROG_BUSY || state_reg == ST_PROG_ERR)
                            && !prog_data_reg[POLL_BIT];
    status_byte[TOG_BIT]  = tog_reg;
    status_byte[ERR_BIT]  = err_reg;
    status_byte[WIN_BIT]  = state_reg == ST_SE_BUSY
                            || state_reg == ST_SUSPENDING;
  end

  // Toggle flips only on status reads, so it freezes once idle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tog_reg <= 1'b0;
    end else if (rd && status_rd) begin
      tog_reg <= ~tog_reg;
    end
  end

  // ==========================================================================
  // Read data, one cycle after the strobe and only then
  always_ff @(posedge core_clk) begin
    if (srst || !rd) begin
      rdata_reg <= '0;
    end else if (status_rd) begin
      rdata_reg <= status_byte;
    end else if (!any_sel) begin
      rdata_reg <= '0;
    end else if (invalid_reg[sect] || (state_reg == ST_SUSPENDED && ers_mask_reg[sect])) begin
      rdata_reg <= INVALID_BYTE;
    end else begin
      rdata_reg <= mem[idx];
    end
  end

  // Ready/busy pin low while an embedded algorithm owns the array
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ready_reg <= 1'b1;
    end else begin
      ready_reg <= !(state_next inside {ST_PROG_BUSY, ST_BULK_BUSY, ST_WINDOW,
                                        ST_SE_BUSY, ST_SUSPENDING});
    end
  end

  assign rdata          = rdata_reg;
  assign ready_busy_pin = ready_reg;

  // ==========================================================================
  // Checks
  localparam int SUSP_LO = 1;
  localparam int SUSP_HI = 600;
  localparam int TMO_HI  = 80;

  property p_poll_inverse;
    @(posedge core_clk) disable iff (srst)
    (rd && status_rd && state_reg == ST_PROG_BUSY)
      |=> rdata_reg[POLL_BIT] == !$past(prog_data_reg[POLL_BIT]);
  endproperty
  a_poll_inverse: assert property (p_poll_inverse) else $error("polling flag not inverted");

  property p_toggle_flips;
    @(posedge core_clk) disable iff (srst)
    (rd && status_rd) ##1 (rd && status_rd)
      |=> rdata_reg[TOG_BIT] != $past(rdata_reg[TOG_BIT]);
  endproperty
  a_toggle_flips: assert property (p_toggle_flips) else $error("toggle flag held still");

  property p_erase_poll_zero;
    @(posedge core_clk) disable iff (srst)
    (rd && status_rd && state_reg == ST_SE_BUSY)
      |=> !rdata_reg[POLL_BIT] && rdata_reg[WIN_BIT];
  endproperty
  a_erase_poll_zero: assert property (p_erase_poll_zero) else $error("erase status wrong");

  property p_window_flag;
    @(posedge core_clk) disable iff (srst)
    (rd && status_rd && state_reg == ST_WINDOW) |=> !rdata_reg[WIN_BIT];
  endproperty
  a_window_flag: assert property (p_window_flag) else $error("window flag set early");

  property p_bulk_refuses;
    @(posedge core_clk) disable iff (srst)
    (state_reg == ST_BULK_BUSY && wr)
      |=> state_reg inside {ST_BULK_BUSY, ST_READ, ST_BULK_ERR};
  endproperty
  a_bulk_refuses: assert property (p_bulk_refuses) else $error("bulk erase took a command");

  property p_bypass_ignores;
    @(posedge core_clk) disable iff (srst)
    (state_reg == ST_BYP && wr && wd != CMD_PROGRAM && wd != CMD_BYP_EXIT1)
      |=> state_reg == ST_BYP;
  endproperty
  a_bypass_ignores: assert property (p_bypass_ignores) else $error("bypass left on bad cmd");

  property p_window_abort;
    @(posedge core_clk) disable iff (srst)
    (state_reg == ST_WINDOW && wr && wd != CMD_SECTOR && wd != CMD_SUSPEND)
      |=> state_reg == ST_READ;
  endproperty
  a_window_abort: assert property (p_window_abort) else $error("window not aborted");

  property p_suspend_time;
    @(posedge core_clk) disable iff (srst)
    (state_reg != ST_SUSPENDING ##1 state_reg == ST_SUSPENDING)
      |-> ##[SUSP_LO:SUSP_HI] state_reg == ST_SUSPENDED;
  endproperty
  a_suspend_time: assert property (p_suspend_time) else $error("suspend too slow");

  property p_reset_aborts;
    @(posedge core_clk) disable iff (srst)
    (state_reg == ST_SE_BUSY && wr && wd == CMD_RESET) |=> state_reg == ST_READ && ready_reg;
  endproperty
  a_reset_aborts: assert property (p_reset_aborts) else $error("reset did not abort erase");

  property p_bad_program_errs;
    @(posedge core_clk) disable iff (srst)
    (state_reg == ST_PROG_BUSY && cnt_reg == '0
     && (prog_data_reg & ~mem[prog_idx_reg]) != '0)
      |-> ##[1:TMO_HI] err_reg;
  endproperty
  a_bad_program_errs: assert property (p_bad_program_errs) else $error("no error flag");
endmodule // fpes_sequencer

// ===== test/fpes_host_model.sv
// Core-side bus master model issuing flash command and read cycles.
// Assumes tasks are called right after a rising core_clk edge.
`timescale 1ns/1ps
module fpes_host_model import fpes_pkg::*; (
  // Clock
  input  wire logic           core_clk,
  // Bus and sector selects toward the sequencer
  output fpes_bus_req_t       bus_req,
  output logic [PRI_SECT-1:0] pri_sel,
  output logic [SEC_SECT-1:0] sec_sel
);
  // ==========================================================================
  // Bus cycles
  initial begin
    bus_req = '0;
    pri_sel = '0;
    sec_sel = '0;
  end
  // One cycle; strobe held until the next call, so no double assignment
  task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w, r, input int s);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
    pri_sel <= (s >= 0 && s < PRI_SECT) ? PRI_SECT'(1 << s) : '0;
    sec_sel <= (s >= PRI_SECT) ? SEC_SECT'(1 << (s - PRI_SECT)) : '0;
    @(posedge core_clk);
  endtask
  // Idle lines flip every cycle rather than hold the last value
  task automatic idle(input int n);
    repeat (n) cyc(~bus_req.addr, ~bus_req.wdata, 1'b0, 1'b0, -1);
  endtask
  // Two standard unlock writes
  task automatic unlock();
    cyc({4'h0, UNLOCK_ADDR1}, CMD_UNLOCK1, 1'b1, 1'b0, -1);
    cyc({4'h0, UNLOCK_ADDR2}, CMD_UNLOCK2, 1'b1, 1'b0, -1);
  endtask
endmodule // fpes_host_model

// ===== test/flash_program_erase_sequencer_tb_top.sv
// Self-checking bench: host model drives, monitor scores read data.
// Assumes the sequencer package and 25 ns core clock.
`timescale 1ns/1ps
module flash_program_erase_sequencer_tb_top import fpes_pkg::*;;
  typedef struct packed { logic [7:0] m; logic [7:0] v; logic tg; } fpes_exp_t;
  logic                core_clk, srst, ready_busy_pin;
  logic                rd_d = 1'b0;
  logic [7:0]          rdata, last, d;
  logic [15:0]         ra;
  fpes_bus_req_t       bus_req;
  logic [PRI_SECT-1:0] pri_sel;
  logic [SEC_SECT-1:0] sec_sel;
  fpes_exp_t           expq[$];
  fpes_exp_t           e;
  int                  err_count = 0;
  int                  n_compared = 0;
  int                  seed = 32'h6674_d38b;
  // ==========================================================================
  // Clock, partner, design
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  fpes_host_model host (.core_clk(core_clk), .bus_req(bus_req), .pri_sel(pri_sel),
                        .sec_sel(sec_sel));
  fpes_sequencer DUT (.core_clk(core_clk), .srst(srst), .bus_req(bus_req), .rdata(rdata),
                      .primary_sector_selects(pri_sel), .secondary_sector_selects(sec_sel),
                      .ready_busy_pin(ready_busy_pin));
  // ==========================================================================
  // Checking
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Monitor: read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    rd_d <= bus_req.rd;
    if (rd_d) begin
      e = expq.pop_front();
      if (e.tg) e.v[TOG_BIT] = ~last[TOG_BIT];
      chk(rdata & e.m, e.v & e.m);
      last = rdata;
    end
  end
  task automatic rdx(input logic [15:0] a, input int s, input logic [7:0] m, v, input logic tg = 0);
    expq.push_back('{m, v, tg});
    host.cyc(a, 8'h00, 1'b0, 1'b1, s);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] dd, input int s);
    host.cyc(a, dd, 1'b1, 1'b0, s);
  endtask
  // Bounded wait for the ready pin
  task automatic wait_rdy(input int n);
    int k;
    k = 0;
    host.idle(1);
    while (ready_busy_pin !== 1'b1 && k < n) begin
      host.idle(1);
      k++;
    end
    if (k >= n) chk({7'h0, ready_busy_pin}, 8'h01);
  endtask
  task automatic close_out();
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog well beyond the longest erase path
  initial begin
    #(25 * 30000);
    err_count++;
    close_out();
  end
  // ==========================================================================
  // Scenarios
  initial begin
    srst = 1'b1;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    // Command cycles with a don't-care address use a random one, except the fixed bypass exit writes
    ra = 16'($random(seed));
    chk({7'h0, ready_busy_pin}, 8'h01);
    host.idle(1);
    host.unlock();
    wr(ra, CMD_ERASE_SET, -1);
    host.unlock();
    wr({4'h0, UNLOCK_ADDR1}, CMD_BULK, -1);
    rdx(16'h0002, 3, 8'hA0, 8'h00);
    rdx(16'h0002, 3, 8'h40, 8'h00, 1'b1);
    wr(ra, CMD_RESET, -1);
    host.idle(2);
    chk({7'h0, ready_busy_pin}, 8'h00);
    wait_rdy(2000);
    rdx(16'h0002, 3, 8'hFF, ERASED_BYTE);
    d = 8'($random(seed)) & 8'hFE;
    host.unlock();
    wr(ra, CMD_PROGRAM, -1);
    wr(16'h0007, d, 5);
    rdx(16'h0007, 5, 8'hA0, {~d[7], 7'h0});
    wait_rdy(200);
    rdx(16'h0007, 5, 8'hFF, d);
    host.unlock();
    wr(ra, CMD_PROGRAM, -1);
    wr(16'h0007, ERASED_BYTE, 5);
    host.idle(PROG_TMO_CYCLES + 8);
    rdx(16'h0007, 5, 8'h20, 8'h20);
    wr(ra, CMD_RESET, -1);
    rdx(16'h0007, 5, 8'hFF, d);
    host.unlock();
    wr(ra, CMD_BYPASS, -1);
    d = 8'($random(seed));
    wr(ra, CMD_PROGRAM, -1);
    wr(16'h0001, d, 6);
    wait_rdy(200);
    rdx(16'h0001, 6, 8'hFF, d);
    wr(ra, CMD_RESET, -1);
    wr(ra, CMD_PROGRAM, -1);
    wr(16'h0002, 8'h5A, 6);
    wait_rdy(200);
    rdx(16'h0002, 6, 8'hFF, 8'h5A);
    wr(16'h0123, CMD_BYP_EXIT1, -1);
    wr(16'h0456, CMD_BYP_EXIT2, -1);
    wr(ra, CMD_PROGRAM, -1);
    wr(16'h0003, 8'h00, 6);
    host.idle(20);
    rdx(16'h0003, 6, 8'hFF, ERASED_BYTE);
    ra = 16'($random(seed));
    host.unlock();
    wr(ra, CMD_ERASE_SET, -1);
    host.unlock();
    wr(ra, CMD_SECTOR, 5);
    rdx(16'h0007, 5, 8'h08, 8'h00);
    host.idle(WINDOW_CYCLES + 4);
    rdx(16'h0007, 5, 8'h88, 8'h08);
    wr(ra, CMD_SUSPEND, 5);
    host.idle(SUSP_CYCLES + 4);
    rdx(16'h0001, 6, 8'hFF, d);
    rdx(16'h0007, 5, 8'hFF, INVALID_BYTE);
    wr(ra, CMD_RESUME, 5);
    wait_rdy(1000);
    rdx(16'h0007, 5, 8'hFF, ERASED_BYTE);
    // Reset-flash inside the window aborts to read at once
    host.unlock();
    wr(ra, CMD_ERASE_SET, -1);
    host.unlock();
    wr(ra, CMD_SECTOR, 7);
    wr(ra, CMD_RESET, 7);
    host.idle(1);
    chk({7'h0, ready_busy_pin}, 8'h01);
    // Reset-flash in a running erase aborts and spoils the sector
    host.unlock();
    wr(ra, CMD_ERASE_SET, -1);
    host.unlock();
    wr(ra, CMD_SECTOR, 7);
    host.idle(WINDOW_CYCLES + 4);
    wr(ra, CMD_RESET, 7);
    host.idle(1);
    chk({7'h0, ready_busy_pin}, 8'h01);
    rdx(16'h0007, 7, 8'hFF, INVALID_BYTE);
    host.idle(2);
    close_out();
  end
endmodule // flash_program_erase_sequencer_tb_top
